// [hw/gpc_top.sv]
// pin buffer control, debounce, edge and drive check logic for 16 pins
`timescale 1ns/1ps
`default_nettype none
module gpc_top (
    // clock and reset
    input  wire logic                   mclk_in,
    input  wire logic                   srst_in,
    // register port
    input  wire gpc_pkg::gpc_bus_req_s  bus_in,
    output logic [7:0]                  rdata_out,
    // slow oscillator tick, one cycle pulse per period
    input  wire logic                   slow_tick_in,
    // pins
    input  wire logic [15:0]            pin_in,
    output logic [15:0]                 pin_data_out,
    output logic [15:0]                 high_drive_out,
    output logic [15:0]                 low_drive_out,
    output logic [15:0]                 pull_up_out,
    output logic [15:0]                 pull_down_out,
    output logic [15:0]                 analog_a_out,
    output logic [15:0]                 analog_b_out,
    // core side
    input  wire logic [15:0]            core_data_in,
    output logic [15:0]                 core_level_out,
    output logic                        ext_irq_a_out,
    output logic                        ext_irq_b_out,
    output logic                        irq_out
);
    import gpc_pkg::*;

    gpc_out_cfg_s ocfg [NPINS];
    gpc_in_cfg_s  icfg [NPINS];
    logic [15:0]  rise_flag, fall_flag, chk_flag;
    logic [15:0]  sync1, sync2, raw, deb, deb_q;
    logic [6:0]   dcnt [NPINS];
    logic [15:0]  drv_val;
    logic [2:0]   chk_pipe [NPINS];
    logic [15:0]  chk_exp;
    logic [15:0]  stat, mask;
    logic [15:0]  irq_a_vec, irq_b_vec, pin_evt, stat_wr_clr, next_stat;
    logic [7:0]   next_rdata;

    // decode: low nibble picks the pin
    wire       out_hit = bus_in.addr[15:4] == OUT_BASE[15:4];
    wire       in_hit  = bus_in.addr[15:4] == IN_BASE[15:4];
    wire [3:0] idx     = bus_in.addr[3:0];
    wire       stat_lo = bus_in.addr == STAT_ADDR;
    wire       stat_hi = bus_in.addr == STAT_ADDR + 16'h0001;
    wire       mask_lo = bus_in.addr == MASK_ADDR;
    wire       mask_hi = bus_in.addr == MASK_ADDR + 16'h0001;

    always_ff @(posedge mclk_in) begin
        sync1 <= pin_in;
        sync2 <= sync1;
    end

    genvar g;
    generate
        for (g = 0; g < NPINS; g++) begin : g_pin
            logic [6:0] lim;
            logic       lvl;
            logic       rise_ev, fall_ev, chk_ev, wr_in;
            // buffer disabled reads as zero, then optional inversion
            assign lvl = (sync2[g] & icfg[g].input_buffer_en)
                         ^ ocfg[g].input_invert; // R3
            assign raw[g] = lvl;
            assign lim = (icfg[g].debounce_sel == DB_4_CODE)  ? DB_4 :
                         (icfg[g].debounce_sel == DB_16_CODE) ? DB_16 :
                         DB_64;
            assign drv_val[g] = core_data_in[g] ^ ocfg[g].output_invert; // R6
            assign rise_ev = deb[g] & ~deb_q[g]; // R2
            assign fall_ev = ~deb[g] & deb_q[g]; // R2
            // compare drive with sample taken three clocks after change
            assign chk_ev  = icfg[g].drive_check_en & chk_pipe[g][CHECK_DELAY-1]
                             & (raw[g] != chk_exp[g]);
            assign wr_in = bus_in.wr & in_hit & (idx == 4'(g)); // R15

            always_ff @(posedge mclk_in) begin
                if (srst_in) begin
                    ocfg[g]      <= gpc_out_cfg_s'(CFG_RESET); // R1 R4 R5 R7 R8
                    icfg[g]      <= gpc_in_cfg_s'(CFG_RESET);
                    dcnt[g]      <= 7'h00;
                    deb[g]       <= 1'b0;
                    deb_q[g]     <= 1'b0;
                    rise_flag[g] <= 1'b0;
                    fall_flag[g] <= 1'b0;
                    chk_flag[g]  <= 1'b0;
                    chk_pipe[g]  <= 3'h0;
                    chk_exp[g]   <= 1'b0;
                end else begin
                    if (bus_in.wr && out_hit && idx == 4'(g))
                        ocfg[g] <= gpc_out_cfg_s'(bus_in.wdata); // R15
                    if (wr_in)
                        icfg[g] <= gpc_in_cfg_s'(bus_in.wdata); // R9 R10
                    // debounce counts slow ticks of a stable differing level
                    if (icfg[g].debounce_sel == DB_OFF_CODE) begin // R14
                        deb[g]  <= raw[g];
                        dcnt[g] <= 7'h00;
                    end else if (raw[g] == deb[g]) begin
                        dcnt[g] <= 7'h00;
                    end else if (slow_tick_in) begin
                        if (dcnt[g] + 7'h01 >= lim) begin // R14
                            deb[g]  <= raw[g];
                            dcnt[g] <= 7'h00;
                        end else begin
                            dcnt[g] <= dcnt[g] + 7'h01;
                        end
                    end
                    deb_q[g] <= deb[g];
                    // set wins over the clear by writing enable zero
                    if (rise_ev && icfg[g].rise_edge_irq_en)
                        rise_flag[g] <= 1'b1; // R11
                    else if (wr_in && !bus_in.wdata[5])
                        rise_flag[g] <= 1'b0; // R11
                    if (fall_ev && icfg[g].fall_edge_irq_en)
                        fall_flag[g] <= 1'b1; // R12
                    else if (wr_in && !bus_in.wdata[4])
                        fall_flag[g] <= 1'b0; // R12
                    chk_pipe[g] <= {chk_pipe[g][1:0],
                                    drv_val[g] != pin_data_out[g]};
                    // launched value kept for its compare slot; a second
                    // change inside three clocks replaces it
                    if (drv_val[g] != pin_data_out[g])
                        chk_exp[g] <= drv_val[g]; // R13
                    if (chk_ev)
                        chk_flag[g] <= 1'b1; // R13
                    else if (!icfg[g].drive_check_en)
                        chk_flag[g] <= 1'b0; // R13
                end
            end

            a_rise_set: assert property (@(posedge mclk_in) disable iff (srst_in)
                rise_ev && icfg[g].rise_edge_irq_en |=> rise_flag[g]) // R11
                else $error("rise flag missed");
            a_fall_set: assert property (@(posedge mclk_in) disable iff (srst_in)
                fall_ev && icfg[g].fall_edge_irq_en |=> fall_flag[g]) // R12
                else $error("fall flag missed");
            a_check_clr: assert property (@(posedge mclk_in) disable iff (srst_in)
                !icfg[g].drive_check_en && !chk_ev |=> !chk_flag[g]) // R13
                else $error("drive check flag not cleared");
            a_dbn_off: assert property (@(posedge mclk_in) disable iff (srst_in)
                icfg[g].debounce_sel == DB_OFF_CODE && !wr_in
                |=> deb[g] == $past(raw[g])) // R14
                else $error("debounce off not transparent");
        end
    endgenerate

    // ordinary pipeline: the compared level is the drive value latched
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            pin_data_out   <= 16'h0000;
            high_drive_out <= 16'h0000;
            low_drive_out  <= 16'h0000;
            pull_up_out    <= 16'h0000;
            pull_down_out  <= 16'h0000;
            analog_a_out   <= 16'h0000;
            analog_b_out   <= 16'h0000;
            core_level_out <= 16'h0000;
            ext_irq_a_out  <= 1'b0;
            ext_irq_b_out  <= 1'b0;
            irq_out        <= 1'b0;
            rdata_out      <= 8'h00;
            stat           <= 16'h0000;
            mask           <= 16'h0000;
        end else begin
            pin_data_out   <= drv_val;
            core_level_out <= deb; // R14
            for (int i = 0; i < NPINS; i++) begin
                high_drive_out[i] <= ocfg[i].high_side_drive_en; // R4
                low_drive_out[i]  <= ocfg[i].low_side_drive_en; // R5
                pull_up_out[i]    <= ocfg[i].pull_up_en; // R8
                pull_down_out[i]  <= ocfg[i].pull_down_en; // R8
                analog_a_out[i]   <= ocfg[i].analog_path_a_en; // R7
                analog_b_out[i]   <= ocfg[i].analog_path_b_en; // R7
            end
            ext_irq_a_out <= |irq_a_vec; // R9
            ext_irq_b_out <= |irq_b_vec; // R9
            // sticky per-pin status, write one clears, set wins
            stat <= (stat & ~(stat_wr_clr)) | pin_evt;
            if (bus_in.wr && mask_lo)
                mask[7:0] <= bus_in.wdata;
            if (bus_in.wr && mask_hi)
                mask[15:8] <= bus_in.wdata;
            irq_out <= |(next_stat & mask);
            rdata_out <= next_rdata;
        end
    end

    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            // drive check only interrupts when a route is enabled
            pin_evt[i]   = rise_flag[i] | fall_flag[i] | (chk_flag[i] &
                           (icfg[i].ext_irq_a_route_en |
                            icfg[i].ext_irq_b_route_en)); // R13
            irq_a_vec[i] = icfg[i].ext_irq_a_route_en & pin_evt[i];
            irq_b_vec[i] = icfg[i].ext_irq_b_route_en & pin_evt[i];
        end
        stat_wr_clr = 16'h0000;
        if (bus_in.wr && stat_lo)
            stat_wr_clr[7:0] = bus_in.wdata;
        if (bus_in.wr && stat_hi)
            stat_wr_clr[15:8] = bus_in.wdata;
        next_stat = (stat & ~stat_wr_clr) | pin_evt;
        next_rdata = 8'h00;
        if (bus_in.rd) begin
            if (out_hit)
                next_rdata = ocfg[idx];
            else if (in_hit)
                next_rdata = {icfg[idx].ext_irq_b_route_en,
                              icfg[idx].ext_irq_a_route_en,
                              rise_flag[idx], fall_flag[idx], // R10
                              icfg[idx].input_buffer_en,
                              chk_flag[idx], deb[idx], raw[idx]};
            else if (stat_lo)
                next_rdata = stat[7:0];
            else if (stat_hi)
                next_rdata = stat[15:8];
            else if (mask_lo)
                next_rdata = mask[7:0];
            else if (mask_hi)
                next_rdata = mask[15:8];
        end
    end

    a_reset_float: assert property (@(posedge mclk_in)
        srst_in |=> high_drive_out == 16'h0000 && low_drive_out == 16'h0000)
        else $error("drivers not off after reset"); // R1
    a_irq_level: assert property (@(posedge mclk_in) disable iff (srst_in)
        ##1 irq_out == |($past(next_stat) & $past(mask)))
        else $error("interrupt level wrong");
    a_pol_out: assert property (@(posedge mclk_in) disable iff (srst_in)
        !$past(srst_in) |-> pin_data_out == $past(drv_val)) // R6
        else $error("output polarity path wrong");
    a_in_pol: assert property (@(posedge mclk_in) disable iff (srst_in)
        ocfg[0].input_invert && !icfg[0].input_buffer_en |-> raw[0]) // R3
        else $error("input invert not applied");
endmodule // gpc_top
`default_nettype wire

// [hw/gpc_pkg.sv]
// constants, types and register map of the pin configuration block
// What this block does
// R1 - after reset every pin floats: both drivers off until software enables
// R2 - each pin has edge detection with latches for rising and falling edges
// R3 - input invert set flips the pin input level before internal use
// R4 - high side drive enable turns on the pull-up driver; resets off
// R5 - low side drive enable turns on the pull-down driver; resets off
// R6 - output invert selects whether output data is inverted
// R7 - two analog path enables connect pin to analog paths; reset off
// R8 - pull up and pull down enables connect the resistors; reset off
// R9 - input bits 7 and 6 route pin to external irq b and a
// R10 - input bits 5 and 4 write edge enables, read edge flags
// R11 - rise flag set on rising edge; cleared by writing enable zero
// R12 - fall flag set on falling edge; cleared by writing enable zero
// R13 - drive check compares input three clocks after output change; flag
// R14 - debounce select: off, 4, 16 or 64 slow oscillator periods
// R15 - register n of each sixteen entry bank controls pin n
package gpc_pkg;
    localparam int          NPINS        = 16;
    localparam logic [15:0] OUT_BASE     = 16'hA100;
    localparam logic [15:0] IN_BASE      = 16'hA110;
    localparam logic [15:0] STAT_ADDR    = 16'hA130;
    localparam logic [15:0] MASK_ADDR    = 16'hA132;
    localparam logic [7:0]  CFG_RESET    = 8'h00;
    localparam int          CHECK_DELAY  = 3;
    localparam logic [6:0]  DB_4         = 7'h04;
    localparam logic [6:0]  DB_16        = 7'h10;
    localparam logic [6:0]  DB_64        = 7'h40;
    localparam logic [1:0]  DB_OFF_CODE  = 2'h0;
    localparam logic [1:0]  DB_4_CODE    = 2'h1;
    localparam logic [1:0]  DB_16_CODE   = 2'h2;

    typedef struct packed {
        logic input_invert;
        logic high_side_drive_en;
        logic low_side_drive_en;
        logic output_invert;
        logic analog_path_b_en;
        logic analog_path_a_en;
        logic pull_up_en;
        logic pull_down_en;
    } gpc_out_cfg_s;

    typedef struct packed {
        logic       ext_irq_b_route_en;
        logic       ext_irq_a_route_en;
        logic       rise_edge_irq_en;
        logic       fall_edge_irq_en;
        logic       input_buffer_en;
        logic       drive_check_en;
        logic [1:0] debounce_sel;
    } gpc_in_cfg_s;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } gpc_bus_req_s;
endpackage

// [tb/gpc_pad_model.sv]
// pad model: resolves pin drivers, pulls and an outside source
`timescale 1ns/1ps
`default_nettype none
module gpc_pad_model (
    // clock and pad controls
    input  wire logic        mclk_in,
    input  wire logic [15:0] data_in,
    input  wire logic [15:0] hi_in,
    input  wire logic [15:0] lo_in,
    input  wire logic [15:0] pu_in,
    input  wire logic [15:0] pd_in,
    // outside source, wins over everything
    input  wire logic [15:0] ext_en_in,
    input  wire logic [15:0] ext_val_in,
    // resolved pin levels
    output logic      [15:0] pin_out
);
    logic [15:0] drift = 16'h0000;
    // floating pins wander so a stale level never looks valid
    always_ff @(posedge mclk_in) drift <= ~pin_out;
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (ext_en_in[i]) pin_out[i] = ext_val_in[i];
            else if (hi_in[i] && data_in[i]) pin_out[i] = 1'b1;
            else if (lo_in[i] && !data_in[i]) pin_out[i] = 1'b0;
            else if (pu_in[i]) pin_out[i] = 1'b1;
            else if (pd_in[i]) pin_out[i] = 1'b0;
            else pin_out[i] = drift[i];
        end
    end
endmodule // gpc_pad_model
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the pin configuration block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import gpc_pkg::*;
    typedef struct packed {logic [3:0] pin; logic [7:0] v;} gpc_row_s;
    localparam gpc_row_s ROWS [4] = '{'{4'h0, 8'h40}, '{4'h5, 8'h20},
                                    '{4'hF, 8'h1F}, '{4'hA, 8'h0C}};
    logic         mclk_in   = 1'b0;
    logic         srst_in   = 1'b1;
    logic         slow_tick = 1'b0;
    gpc_bus_req_s bus       = '0;
    logic [15:0]  core_data = 16'hA5A5;
    logic [15:0]  ext_en    = 16'hFFFF;
    logic [15:0]  ext_val   = 16'h0000;
    logic [15:0]  pins, pdata, hi, lo, pu, pd, ana, anb, level;
    logic [7:0]   rdata;
    logic [7:0]   sh [16];
    logic         irq_a, irq_b, irq;
    int           failures    = 0;
    int           comparisons = 0;
    int           cyc         = 0;

    gpc_top uut (.mclk_in(mclk_in), .srst_in(srst_in), .bus_in(bus),
        .rdata_out(rdata), .slow_tick_in(slow_tick), .pin_in(pins),
        .pin_data_out(pdata), .high_drive_out(hi), .low_drive_out(lo),
        .pull_up_out(pu), .pull_down_out(pd), .analog_a_out(ana),
        .analog_b_out(anb), .core_data_in(core_data),
        .core_level_out(level), .ext_irq_a_out(irq_a),
        .ext_irq_b_out(irq_b), .irq_out(irq));
    gpc_pad_model pad (.mclk_in(mclk_in), .data_in(pdata), .hi_in(hi),
        .lo_in(lo), .pu_in(pu), .pd_in(pd), .ext_en_in(ext_en),
        .ext_val_in(ext_val), .pin_out(pins));

    initial begin
        forever #2 mclk_in = ~mclk_in;
    end

    task automatic test_done();
        $display("Comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // hang guard: the whole sequence needs well under this
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures++;
            test_done();
        end
    end

    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic idle(int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask
    task automatic wr(logic [15:0] a, logic [7:0] d);
        @(posedge mclk_in) bus <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk_in) bus <= '0;
    endtask
    task automatic rd(logic [15:0] a, logic [7:0] e);
        @(posedge mclk_in) bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge mclk_in) bus <= '0;
        #1 chk("rdata", 16'(e), 16'(rdata));
    endtask
    task automatic tick(int n);
        repeat (n) begin
            @(posedge mclk_in) slow_tick <= 1'b1;
            @(posedge mclk_in) slow_tick <= 1'b0;
        end
        #1;
    endtask
    function automatic logic [15:0] col(int b);
        for (int i = 0; i < 16; i++) col[i] = sh[i][b];
    endfunction

    initial begin
        for (int i = 0; i < 16; i++) sh[i] = 8'h00;
        repeat (2) @(posedge mclk_in);
        srst_in <= 1'b0;
        idle(1);
        chk("high_drive", 16'h0000, hi);
        chk("low_drive", 16'h0000, lo);
        rd(OUT_BASE + 16'h000F, 8'h00);
        rd(IN_BASE, 8'h00);
        rd(16'hA140, 8'h00);
        for (int r = 0; r < 4; r++) begin
            sh[ROWS[r].pin] = ROWS[r].v;
            wr(OUT_BASE + 16'(ROWS[r].pin), ROWS[r].v);
            rd(OUT_BASE + 16'(ROWS[r].pin), ROWS[r].v);
            chk("high_drive", col(6), hi);
            chk("low_drive", col(5), lo);
            chk("pin_data", core_data ^ col(4), pdata);
            chk("analog_b", col(3), anb);
            chk("analog_a", col(2), ana);
            chk("pull_up", col(1), pu);
            chk("pull_down", col(0), pd);
        end
        // rising edge on pin 6, routed to irq a
        wr(IN_BASE + 16'h0006, 8'h68);
        ext_val[6] <= 1'b1;
        idle(8);
        rd(IN_BASE + 16'h0006, 8'h6B);
        chk("ext_irq_a", 16'h0001, 16'(irq_a));
        wr(MASK_ADDR, 8'h40);
        idle(2);
        chk("irq", 16'h0001, 16'(irq));
        wr(MASK_ADDR, 8'h00);
        idle(2);
        chk("irq", 16'h0000, 16'(irq));
        wr(IN_BASE + 16'h0006, 8'h48);
        rd(IN_BASE + 16'h0006, 8'h4B);
        wr(STAT_ADDR, 8'h40);
        wr(MASK_ADDR, 8'h40);
        idle(2);
        chk("irq", 16'h0000, 16'(irq));
        chk("level6", 16'h0001, 16'(level[6]));
        wr(OUT_BASE + 16'h0006, 8'h80);
        idle(4);
        chk("level6", 16'h0000, 16'(level[6]));
        // falling edge on pin 9, routed to irq b, high mask byte
        ext_val[9] <= 1'b1;
        wr(IN_BASE + 16'h0009, 8'h98);
        idle(8);
        ext_val[9] <= 1'b0;
        idle(8);
        rd(IN_BASE + 16'h0009, 8'h98);
        chk("ext_irq_b", 16'h0001, 16'(irq_b));
        wr(MASK_ADDR + 16'h0001, 8'h02);
        idle(2);
        chk("irq", 16'h0001, 16'(irq));
        // drive check on pin 3: first a clean change, then a clash
        wr(OUT_BASE + 16'h0003, 8'h60);
        wr(IN_BASE + 16'h0003, 8'h0C);
        ext_en[3] <= 1'b0;
        core_data[3] <= 1'b1;
        idle(8);
        rd(IN_BASE + 16'h0003, 8'h0B);
        ext_en[3] <= 1'b1;
        core_data[3] <= 1'b0;
        idle(8);
        core_data[3] <= 1'b1;
        idle(8);
        rd(IN_BASE + 16'h0003, 8'h0C);
        wr(IN_BASE + 16'h0003, 8'h08);
        rd(IN_BASE + 16'h0003, 8'h08);
        // debounce codes 01, 10, 11 on pins 12, 13, 14
        wr(IN_BASE + 16'h000C, {6'h02, DB_4_CODE});
        wr(IN_BASE + 16'h000D, {6'h02, DB_16_CODE});
        wr(IN_BASE + 16'h000E, 8'h0B);
        ext_val[14:12] <= 3'b111;
        idle(4);
        tick(2);
        chk("level12", 16'h0000, 16'(level[12]));
        tick(6);
        idle(2);
        chk("level12", 16'h0001, 16'(level[12]));
        chk("level13", 16'h0000, 16'(level[13]));
        tick(10);
        idle(2);
        chk("level13", 16'h0001, 16'(level[13]));
        chk("level14", 16'h0000, 16'(level[14]));
        // reset again in mid-run
        srst_in <= 1'b1;
        idle(2);
        chk("high_drive", 16'h0000, hi);
        chk("low_drive", 16'h0000, lo);
        srst_in <= 1'b0;
        idle(1);
        rd(OUT_BASE + 16'h0005, 8'h00);
        test_done();
    end
endmodule // tb
`default_nettype wire
